// [hw/tovh_map.vh]
// Register offsets, field positions and reset values of the transmit overhead bank
`ifndef TOVH_MAP_VH
`define TOVH_MAP_VH

// Register index within one port (byte address is four times the index)
`define TOVH_OFF_IDLE_CODE_FIRST 9'h120
`define TOVH_OFF_IDLE_CODE_LAST  9'h13F
`define TOVH_OFF_IDLE_EN_FIRST   9'h150
`define TOVH_OFF_IDLE_EN_LAST    9'h153
`define TOVH_OFF_FW_REVISION     9'h161
`define TOVH_OFF_FDL             9'h162
`define TOVH_OFF_BOC             9'h163
`define TOVH_OFF_SLC1_ALIGN      9'h164
`define TOVH_OFF_SLC2_NONALIGN   9'h165
`define TOVH_OFF_SLC3            9'h166
`define TOVH_OFF_MODE            9'h170
`define TOVH_OFF_STATUS          9'h171

// Port stride in register indices
`define TOVH_PORT_STRIDE         12'h200

// Reset values
`define TOVH_RST_ZERO            8'h00
`define TOVH_RST_ALIGN           8'h1B
`define TOVH_RST_NONALIGN        8'h40

// Field layouts
`define TOVH_BOC_MASK            8'h3F
`define TOVH_MODE_E1_BIT         0
`define TOVH_MODE_SF_BIT         1
`define TOVH_SLC2_FORCE_ONE      8'h10
`define TOVH_SLC2_FORCE_ZERO     8'h28
`define TOVH_SLC3_FORCE_ONE      8'h80
`define TOVH_NALIGN_FORCE_ONE    8'h40

// Serialiser bit positions
`define TOVH_BYTE_LAST_BIT       3'h7
`define TOVH_SF_LAST_BIT         3'h5

`endif

// [hw/tovh_buf2.v]
// Two-entry valid/ready buffer
module tovh_buf2 #(
  parameter W = 16
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  reg  [W-1:0] slot_reg [0:1];
  reg          wr_ptr_reg;
  reg          rd_ptr_reg;
  reg  [1:0]   count_reg;
  wire         push;
  wire         pop;

  assign in_ready  = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data  = slot_reg[rd_ptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_reg[0] <= {W{1'b0}};
      slot_reg[1] <= {W{1'b0}};
      wr_ptr_reg  <= 1'b0;
      rd_ptr_reg  <= 1'b0;
      count_reg   <= 2'h0;
    end else begin
      if (push) begin
        slot_reg[wr_ptr_reg] <= in_data;
        wr_ptr_reg           <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 2'h1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 2'h1;
      end
    end
  end
endmodule // tovh_buf2

// [hw/tovh_lsb_ser.v]
// Byte serialiser, least significant bit first, reload at byte boundary
`include "tovh_map.vh"
module tovh_lsb_ser (
  input  wire       pclk,
  input  wire       presetn,
  input  wire [7:0] load_byte,
  input  wire       short_byte,
  input  wire       advance,
  output wire       bit_out,
  output wire [2:0] bit_pos
);
  reg  [7:0] shadow_reg;
  reg  [2:0] pos_reg;
  wire [2:0] last_pos;

  assign last_pos = short_byte ? `TOVH_SF_LAST_BIT : `TOVH_BYTE_LAST_BIT;
  assign bit_out  = shadow_reg[pos_reg];
  assign bit_pos  = pos_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_reg <= `TOVH_RST_ZERO;
      pos_reg    <= 3'h0;
    end else if (advance) begin
      if (pos_reg >= last_pos) begin
        shadow_reg <= load_byte;
        pos_reg    <= 3'h0;
      end else begin
        pos_reg <= pos_reg + 3'h1;
      end
    end
  end
endmodule // tovh_lsb_ser

// [hw/tovh_regs.v]
// Transmit overhead register bank for eight ports, APB slave with datapath hooks
//
// Added by the designer: the APB register port.
`include "tovh_map.vh"
module tovh_regs #(
  // Arbitrary value, identifies nothing
  parameter [7:0] FW_REVISION = 8'h5A
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         psel,
  input  wire         penable,
  input  wire         pwrite,
  input  wire [13:0]  paddr,
  input  wire [31:0]  pwdata,
  output wire         pready,
  output wire [31:0]  prdata,
  output wire         pslverr,
  input  wire         bp_valid,
  output wire         bp_ready,
  input  wire [2:0]   bp_port,
  input  wire [4:0]   bp_channel,
  input  wire [7:0]   bp_data,
  output wire         tx_valid,
  input  wire         tx_ready,
  output wire [7:0]   tx_data,
  output wire [2:0]   tx_port,
  output wire [4:0]   tx_channel,
  input  wire [7:0]   fdl_advance,
  output wire [7:0]   fdl_bit,
  input  wire [7:0]   frame_start,
  output wire [47:0]  boc_active,
  output wire [191:0] slc_active,
  output wire [63:0]  e1_align_active,
  output wire [63:0]  e1_nonalign_active,
  output wire [7:0]   e1_mode,
  output wire [7:0]   superframe_mode
);
  // Storage, one entry per port, idle codes 32 entries per port
  reg  [7:0]  idle_code_reg [0:255];
  reg  [31:0] idle_en_reg   [0:7];
  reg  [7:0]  fdl_reg       [0:7];
  reg  [5:0]  boc_reg       [0:7];
  reg  [7:0]  slc1_reg      [0:7];
  reg  [7:0]  slc2_reg      [0:7];
  reg  [7:0]  slc3_reg      [0:7];
  reg  [7:0]  align_reg     [0:7];
  reg  [7:0]  nonalign_reg  [0:7];
  reg  [7:0]  e1_reg;
  reg  [7:0]  sf_reg;
  reg  [7:0]  rdata_reg;
  reg         err_reg;
  reg  [7:0]  rd_next;
  reg         err_next;
  wire [23:0] fdl_pos_all;
  wire [15:0] buf_in;
  wire [15:0] buf_out;
  wire [2:0]  acc_port;
  wire [8:0]  acc_off;
  wire        acc_setup;
  wire        acc_write;
  wire        acc_idle_code;
  wire        acc_idle_en;
  wire        acc_e1;
  wire        bp_subst;
  wire [7:0]  bp_byte;
  integer     i;

  // Fixed spoiler and signal bits forced in hardware
  function [7:0] fix_bits;
    input [7:0] value;
    input [7:0] force_one;
    input [7:0] force_zero;
    begin
      fix_bits = (value | force_one) & ~force_zero;
    end
  endfunction

  // port from index bits, offset below stride
  assign acc_port      = paddr[13:11];
  assign acc_off       = paddr[10:2];
  assign acc_setup     = psel & ~penable;
  assign acc_write     = psel & penable & pwrite & ~err_reg;
  assign acc_idle_code = (acc_off >= `TOVH_OFF_IDLE_CODE_FIRST) && (acc_off <= `TOVH_OFF_IDLE_CODE_LAST);
  assign acc_idle_en   = (acc_off >= `TOVH_OFF_IDLE_EN_FIRST) && (acc_off <= `TOVH_OFF_IDLE_EN_LAST);
  assign acc_e1        = e1_reg[acc_port];

  // Zero wait states: answer prepared in setup
  assign pready  = 1'b1;
  assign prdata  = {24'h000000, rdata_reg};
  assign pslverr = err_reg & psel & penable;

  always @* begin
    rd_next  = `TOVH_RST_ZERO;
    err_next = 1'b0;
    if (acc_idle_code) begin
      rd_next = idle_code_reg[{acc_port, acc_off[4:0]}];
    end else if (acc_idle_en) begin
      rd_next = idle_en_reg[acc_port][{acc_off[1:0], 3'b000} +: 8];
    end else begin
      case (acc_off)
        `TOVH_OFF_FW_REVISION: begin
          rd_next = FW_REVISION;
        end
        `TOVH_OFF_FDL: begin
          rd_next = fdl_reg[acc_port];
        end
        `TOVH_OFF_BOC: begin
          rd_next = {2'b00, boc_reg[acc_port]};
        end
        `TOVH_OFF_SLC1_ALIGN: begin
          rd_next = acc_e1 ? align_reg[acc_port] : slc1_reg[acc_port];
        end
        `TOVH_OFF_SLC2_NONALIGN: begin
          rd_next = acc_e1 ? nonalign_reg[acc_port] : slc2_reg[acc_port];
        end
        `TOVH_OFF_SLC3: begin
          // Only a T1 register here
          rd_next  = acc_e1 ? `TOVH_RST_ZERO : slc3_reg[acc_port];
          err_next = acc_e1;
        end
        `TOVH_OFF_MODE: begin
          rd_next = {6'h00, sf_reg[acc_port], e1_reg[acc_port]};
        end
        `TOVH_OFF_STATUS: begin
          rd_next = {5'h00, fdl_pos_all[{acc_port, 2'b00} - {2'b00, acc_port} +: 3]};
        end
        default: begin
          err_next = 1'b1;
        end
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= `TOVH_RST_ZERO;
      err_reg   <= 1'b0;
    end else if (acc_setup) begin
      rdata_reg <= pwrite ? `TOVH_RST_ZERO : rd_next;
      err_reg   <= err_next;
    end
  end

  // Register writes, access phase only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < 256; i = i + 1) begin
        idle_code_reg[i] <= `TOVH_RST_ZERO;
      end
      for (i = 0; i < 8; i = i + 1) begin
        idle_en_reg[i]  <= 32'h00000000;
        fdl_reg[i]      <= `TOVH_RST_ZERO;
        boc_reg[i]      <= 6'h00;
        slc1_reg[i]     <= `TOVH_RST_ZERO;
        slc2_reg[i]     <= `TOVH_SLC2_FORCE_ONE;
        slc3_reg[i]     <= `TOVH_SLC3_FORCE_ONE;
        align_reg[i]    <= `TOVH_RST_ALIGN;
        nonalign_reg[i] <= `TOVH_RST_NONALIGN;
      end
      e1_reg <= `TOVH_RST_ZERO;
      sf_reg <= `TOVH_RST_ZERO;
    end else if (acc_write) begin
      if (acc_idle_code) begin
        idle_code_reg[{acc_port, acc_off[4:0]}] <= pwdata[7:0];
      end else if (acc_idle_en) begin
        idle_en_reg[acc_port][{acc_off[1:0], 3'b000} +: 8] <= pwdata[7:0];
      end else begin
        case (acc_off)
          `TOVH_OFF_FDL: begin
            fdl_reg[acc_port] <= pwdata[7:0];
          end
          `TOVH_OFF_BOC: begin
            boc_reg[acc_port] <= pwdata[5:0];
          end
          `TOVH_OFF_SLC1_ALIGN: begin
            if (acc_e1) begin
              // pattern bits held, only bit 7 writable
              align_reg[acc_port] <= fix_bits(pwdata[7:0], `TOVH_RST_ALIGN, ~`TOVH_RST_ALIGN & 8'h7F);
            end else begin
              slc1_reg[acc_port] <= pwdata[7:0];
            end
          end
          `TOVH_OFF_SLC2_NONALIGN: begin
            if (acc_e1) begin
              nonalign_reg[acc_port] <= fix_bits(pwdata[7:0], `TOVH_NALIGN_FORCE_ONE, `TOVH_RST_ZERO);
            end else begin
              slc2_reg[acc_port] <= fix_bits(pwdata[7:0], `TOVH_SLC2_FORCE_ONE, `TOVH_SLC2_FORCE_ZERO);
            end
          end
          `TOVH_OFF_SLC3: begin
            slc3_reg[acc_port] <= fix_bits(pwdata[7:0], `TOVH_SLC3_FORCE_ONE, `TOVH_RST_ZERO);
          end
          `TOVH_OFF_MODE: begin
            e1_reg[acc_port] <= pwdata[`TOVH_MODE_E1_BIT];
            sf_reg[acc_port] <= pwdata[`TOVH_MODE_SF_BIT];
          end
          default: begin
            e1_reg <= e1_reg;
          end
        endcase
      end
    end
  end

  assign e1_mode         = e1_reg;
  assign superframe_mode = sf_reg;

  assign bp_subst = idle_en_reg[bp_port][bp_channel];
  // whole code byte, MSB first on the line so bit 0 goes last
  assign bp_byte  = bp_subst ? idle_code_reg[{bp_port, bp_channel}] : bp_data;
  assign buf_in   = {bp_port, bp_channel, bp_byte};

  // Buffer absorbs a one-cycle receiver stall without losing a byte
  tovh_buf2 #(
    .W (16)
  ) u_buf (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (bp_valid),
    .in_ready  (bp_ready),
    .in_data   (buf_in),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (buf_out)
  );

  assign tx_port    = buf_out[15:13];
  assign tx_channel = buf_out[12:8];
  assign tx_data    = buf_out[7:0];

  genvar p;
  generate
    for (p = 0; p < 8; p = p + 1) begin : g_port
      reg  [5:0] boc_act_reg;
      reg  [7:0] slc1_act_reg;
      reg  [7:0] slc2_act_reg;
      reg  [7:0] slc3_act_reg;
      reg  [7:0] align_act_reg;
      reg  [7:0] nonalign_act_reg;
      wire       ser_bit;

      // byte-wise data link, frame bits in superframe
      tovh_lsb_ser u_ser (
        .pclk       (pclk),
        .presetn    (presetn),
        .load_byte  (fdl_reg[p]),
        .short_byte (sf_reg[p]),
        .advance    (fdl_advance[p]),
        .bit_out    (ser_bit),
        .bit_pos    (fdl_pos_all[3*p +: 3])
      );

      assign fdl_bit[p] = ser_bit & ~e1_reg[p];

      // snapshot at frame start so no torn value goes out
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          boc_act_reg      <= 6'h00;
          slc1_act_reg     <= `TOVH_RST_ZERO;
          slc2_act_reg     <= `TOVH_SLC2_FORCE_ONE;
          slc3_act_reg     <= `TOVH_SLC3_FORCE_ONE;
          align_act_reg    <= `TOVH_RST_ALIGN;
          nonalign_act_reg <= `TOVH_RST_NONALIGN;
        end else if (frame_start[p]) begin
          boc_act_reg      <= e1_reg[p] ? 6'h00 : boc_reg[p];
          slc1_act_reg     <= slc1_reg[p];
          slc2_act_reg     <= slc2_reg[p];
          slc3_act_reg     <= slc3_reg[p];
          align_act_reg    <= align_reg[p];
          nonalign_act_reg <= nonalign_reg[p];
        end
      end

      assign boc_active[6*p +: 6]          = boc_act_reg;
      assign slc_active[24*p +: 24]        = {slc3_act_reg, slc2_act_reg, slc1_act_reg};
      assign e1_align_active[8*p +: 8]     = align_act_reg;
      assign e1_nonalign_active[8*p +: 8]  = nonalign_act_reg;
    end
  endgenerate
endmodule // tovh_regs

// [sim/tovh_chk.sv]
// Port 0 assertion checker for the transmit overhead bank
module tovh_chk (
  input logic         pclk,
  input logic         presetn,
  input logic         psel,
  input logic         penable,
  input logic         pready,
  input logic         pslverr,
  input logic         bp_valid,
  input logic         bp_ready,
  input logic         tx_valid,
  input logic         tx_ready,
  input logic [7:0]   tx_data,
  input logic [7:0]   fdl_advance,
  input logic [7:0]   fdl_bit,
  input logic [7:0]   frame_start,
  input logic [47:0]  boc_active,
  input logic [191:0] slc_active,
  input logic [63:0]  e1_nonalign_active,
  input logic [7:0]   e1_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pready_access: assert property (psel && penable |-> pready) else $error("no ready in access");
  a_err_access_only: assert property (pslverr |-> psel && penable) else $error("stray error");
  a_boc_e1_zero: assert property (frame_start[0] && e1_mode[0] |=> boc_active[5:0] == 6'h00)
    else $error("code active in E1");
  // Port 0 only, others share the logic
  a_active_hold: assert property (!frame_start[0] |=> $stable(boc_active[5:0]) && $stable(slc_active[23:0]))
    else $error("active moved off frame");
  a_link_hold: assert property (!fdl_advance[0] |=> $stable(fdl_bit[0]) || $changed(e1_mode[0]))
    else $error("link bit moved");
  a_link_e1_zero: assert property (e1_mode[0] |-> !fdl_bit[0]) else $error("link bit in E1");
  a_spoiler_fixed: assert property (slc_active[12] && !slc_active[13] && !slc_active[11] && slc_active[23])
    else $error("spoiler bits wrong");
  a_nonalign_one: assert property (e1_nonalign_active[6]) else $error("nonalign bit6 low");
  a_tx_stall_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("word lost in stall");
  a_full_refuse: assert property (bp_valid && bp_ready && !tx_ready ##1 bp_valid && bp_ready && !tx_ready
    |=> !bp_ready) else $error("full buffer accepts");
endmodule // tovh_chk

bind tovh_regs tovh_chk u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .bp_valid, .bp_ready,
  .tx_valid, .tx_ready, .tx_data, .fdl_advance, .fdl_bit, .frame_start, .boc_active, .slc_active,
  .e1_nonalign_active, .e1_mode);

// [sim/test_t1e1_tx_overhead_regs.sv]
// Directed bench for the transmit overhead bank
`include "tovh_map.vh"
module test_t1e1_tx_overhead_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, bp_valid = 0, tx_ready = 0;
  logic pready, pslverr, bp_ready, tx_valid;
  logic [13:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [2:0] bp_port = 0, tx_port;
  logic [4:0] bp_channel = 0, tx_channel;
  logic [7:0] bp_data = 0, fdl_advance = 0, frame_start = 0, tx_data, fdl_bit, e1_mode, superframe_mode;
  logic [47:0] boc_active;
  logic [191:0] slc_active;
  logic [63:0] e1_align_active, e1_nonalign_active;
  logic [32:0] rsp;
  int err_total = 0, tests_run = 0;
  tovh_regs uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .bp_valid, .bp_ready, .bp_port, .bp_channel, .bp_data, .tx_valid, .tx_ready, .tx_data, .tx_port,
    .tx_channel, .fdl_advance, .fdl_bit, .frame_start, .boc_active, .slc_active, .e1_align_active,
    .e1_nonalign_active, .e1_mode, .superframe_mode);
  always #25 pclk = ~pclk;
  task automatic chk(input [32:0] g, input [32:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input [2:0] pt, input [8:0] ix, input [7:0] d, input w);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= {pt, ix, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rsp = {pslverr, prdata};
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input [2:0] pt, input [8:0] ix, input [7:0] d);
    apb(pt, ix, d, 1'h1);
  endtask
  task automatic rd(input [2:0] pt, input [8:0] ix, input [7:0] e, input er);
    apb(pt, ix, 8'h00, 1'h0);
    chk(rsp, {er, 24'h0, e});
  endtask
  task automatic pulse(input bit frm);
    @(posedge pclk);
    if (frm) frame_start <= 8'h01;
    else fdl_advance <= 8'h01;
    @(posedge pclk);
    frame_start <= 8'h00;
    fdl_advance <= 8'h00;
    @(negedge pclk);
  endtask
  task automatic push(input [4:0] ch, input [7:0] d);
    @(posedge pclk);
    bp_valid <= 1'h1;
    bp_channel <= ch;
    bp_data <= d;
    do @(posedge pclk); while (bp_ready !== 1'h1);
    bp_valid <= 1'h0;
  endtask
  task automatic pop(input [4:0] ch, input [7:0] e);
    @(posedge pclk);
    tx_ready <= 1'h1;
    do @(posedge pclk); while (tx_valid !== 1'h1);
    chk(33'({tx_port, tx_channel, tx_data}), 33'({3'h0, ch, e}));
    tx_ready <= 1'h0;
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Generous: the directed run needs well under 2000 cycles
  initial begin
    #400000;
    err_total++;
    test_done;
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    wr(0, `TOVH_OFF_FW_REVISION, 8'hFF);
    rd(0, `TOVH_OFF_FW_REVISION, 8'h5A, 0);
    wr(0, `TOVH_OFF_BOC, 8'hFF);
    rd(0, `TOVH_OFF_BOC, 8'h3F, 0);
    wr(0, `TOVH_OFF_FDL, 8'hA5);
    wr(7, `TOVH_OFF_FDL, 8'h3C);
    rd(0, `TOVH_OFF_FDL, 8'hA5, 0);
    rd(7, `TOVH_OFF_FDL, 8'h3C, 0);
    wr(0, `TOVH_OFF_SLC2_NONALIGN, 8'hFF);
    rd(0, `TOVH_OFF_SLC2_NONALIGN, 8'hD7, 0);
    wr(0, `TOVH_OFF_SLC3, 8'h00);
    rd(0, `TOVH_OFF_SLC3, 8'h80, 0);
    rd(0, 9'h100, 8'h00, 1);
    pulse(1);
    chk(33'(slc_active[23:8]), 33'h80D7);
    chk(33'(boc_active[5:0]), 33'h3F);
    $display("register test done");
    // Shadow still empty until the first byte boundary
    for (int i = 0; i < 8; i++) begin
      chk(33'(fdl_bit[0]), 33'h0);
      pulse(0);
    end
    for (int i = 0; i < 8; i++) begin
      chk(33'(fdl_bit[0]), 33'(8'hA5 >> i & 8'h01));
      if (i == 1) wr(0, `TOVH_OFF_FDL, 8'h16);
      pulse(0);
    end
    rd(0, `TOVH_OFF_STATUS, 8'h00, 0);
    wr(0, `TOVH_OFF_MODE, 8'h02);
    for (int i = 0; i < 6; i++) begin
      chk(33'(fdl_bit[0]), 33'(8'h16 >> i & 8'h01));
      pulse(0);
    end
    rd(0, `TOVH_OFF_STATUS, 8'h00, 0);
    $display("data link test done");
    wr(0, `TOVH_OFF_MODE, 8'h01);
    pulse(1);
    chk(33'(boc_active[5:0]), 33'h0);
    rd(0, `TOVH_OFF_SLC1_ALIGN, 8'h1B, 0);
    wr(0, `TOVH_OFF_SLC1_ALIGN, 8'h80);
    rd(0, `TOVH_OFF_SLC1_ALIGN, 8'h9B, 0);
    rd(0, `TOVH_OFF_SLC2_NONALIGN, 8'h40, 0);
    wr(0, `TOVH_OFF_SLC2_NONALIGN, 8'hA0);
    rd(0, `TOVH_OFF_SLC2_NONALIGN, 8'hE0, 0);
    rd(0, `TOVH_OFF_SLC3, 8'h00, 1);
    pulse(1);
    chk(33'({e1_align_active[7:0], e1_nonalign_active[7:0]}), 33'h9BE0);
    chk(33'({e1_mode, superframe_mode}), 33'h0100);
    $display("E1 test done");
    wr(0, 9'h124, 8'h5C);
    wr(0, 9'h13F, 8'hE7);
    wr(0, 9'h150, 8'h10);
    wr(0, 9'h153, 8'h80);
    push(5'h04, 8'h11);
    push(5'h1F, 8'h22);
    @(negedge pclk);
    chk(33'(bp_ready), 33'h0);
    pop(5'h04, 8'h5C);
    pop(5'h1F, 8'hE7);
    push(5'h05, 8'h33);
    pop(5'h05, 8'h33);
    // Back-to-back bytes into a stalled receiver fill both entries
    @(posedge pclk);
    bp_valid <= 1'h1;
    bp_channel <= 5'h06;
    bp_data <= 8'h44;
    do @(posedge pclk); while (bp_ready !== 1'h1);
    bp_data <= 8'h55;
    do @(posedge pclk); while (bp_ready !== 1'h1);
    bp_valid <= 1'h0;
    @(negedge pclk);
    chk(33'(bp_ready), 33'h0);
    pop(5'h06, 8'h44);
    pop(5'h06, 8'h55);
    $display("idle test done");
    test_done;
  end
endmodule // test_t1e1_tx_overhead_regs
